// file: hdl/flash_row_page_control.sv
// Behaviour
// - Each array is split into 128-byte pages of two 64-byte rows.
// - Programming works on one 64-byte row of an armed page; the code programs any word of the whole armed 128-byte page.
// - Normal erase clears one whole 128-byte page, nothing smaller.
// - Erased bits read one, programmed bits read zero.
// - Control bit 2 selects mass erase instead of page erase.
// - Control bits 3 to 7 do nothing; timing is generated internally.
// - First control register at FF88, second at FE08.
// - Programming is single pass, no verify or re-pulse.
// - Any byte is programmed within 40 microseconds.
// - Eight-bit protect register sets the protected start, page granular.
// - Protect register writes need no elevated pin voltage.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module flash_row_page_control (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [flash_pkg::BUS_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [flash_pkg::BUS_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [flash_pkg::BUS_W-1:0] hrdata,
   output logic hresp,
   // Status
   output logic flashBusy
);
   import flash_pkg::*;

   // ==========================================================
   // Reset release
   logic [1:0] rstPipe_ff;
   logic rstn;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rstPipe_ff <= 2'b00;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end
   assign rstn = rstPipe_ff[1];

   // ==========================================================
   // Decode
   function automatic region_t decode(input logic [BUS_W-1:0] a);
      region_t r;
      r = RG_NONE;
      if (a[31:16] == HIGH_ADDR_ZERO) begin
         case (a[15:0])
            ADDR_CTRL1: r = RG_CTRL1;
            ADDR_CTRL2: r = RG_CTRL2;
            ADDR_PROTECT: r = RG_PROTECT;
            ADDR_STATUS: r = RG_STATUS;
            default: r = (a[15:0] < ARRAY_TOP) ? RG_ARRAY : RG_NONE;
         endcase
      end
      return r;
   endfunction

   function automatic logic pageProtected(input logic [3:0] page, input logic [7:0] start);
      return {4'h0, page} >= start;
   endfunction

   // ==========================================================
   // Bus phases
   dphase_t dp_ff;
   logic take, dpArrayRead, dpStall, dpDone, rdOk_ff, armed_ff, busy;
   logic [BUS_W-1:0] regRdata_ff, memRdata;
   logic [7:0] ctrl1_ff, ctrl2_ff, protect_ff;
   logic [TAG_W-1:0] armedTag_ff;
   op_state_t opState_ff;

   assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
   assign busy = (opState_ff != OP_IDLE);
   assign dpArrayRead = dp_ff.active && !dp_ff.write && (dp_ff.region == RG_ARRAY);
   assign dpStall = dp_ff.active && (dp_ff.region == RG_ARRAY) &&
      (busy || (!dp_ff.write && !rdOk_ff));
   assign dpDone = dp_ff.active && !dpStall;
   assign hreadyout = !dpStall;
   assign hresp = HRESP_OKAY;
   assign hrdata = (dp_ff.region == RG_ARRAY) ? memRdata : regRdata_ff;
   assign flashBusy = busy;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dp_ff <= '0;
      end else if (hready) begin
         dp_ff.active <= take;
         dp_ff.write <= hwrite;
         dp_ff.region <= take ? decode(haddr) : RG_NONE;
         dp_ff.addr <= haddr[ADDR_W-1:0];
      end
   end

   // Memory read is one cycle behind, so one wait state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdOk_ff <= 1'b0;
      end else begin
         rdOk_ff <= dpArrayRead && !busy && !rdOk_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         regRdata_ff <= '0;
      end else if (take && !hwrite) begin
         case (decode(haddr))
            RG_CTRL1: regRdata_ff <= {24'h000000, ctrl1_ff};
            RG_CTRL2: regRdata_ff <= {24'h000000, ctrl2_ff};
            RG_PROTECT: regRdata_ff <= {24'h000000, protect_ff};
            RG_STATUS: regRdata_ff <= {30'h0, armed_ff, busy};
            default: regRdata_ff <= '0;
         endcase
      end
   end

   // ==========================================================
   // Registers
   logic regWrite;
   assign regWrite = dpDone && dp_ff.write;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl1_ff <= CTRL_RESET;
         ctrl2_ff <= CTRL_RESET;
      end else if (regWrite && dp_ff.region == RG_CTRL1) begin
         ctrl1_ff <= hwdata[7:0] & CTL_MASK;
      end else if (regWrite && dp_ff.region == RG_CTRL2) begin
         ctrl2_ff <= hwdata[7:0] & CTL_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         protect_ff <= PROTECT_RESET;
      end else if (regWrite && dp_ff.region == RG_PROTECT) begin
         protect_ff <= hwdata[7:0];
      end
   end

   // ==========================================================
   // Operation decisions
   logic [7:0] actCtl;
   logic [TAG_W-1:0] pageTag;
   logic arrayWrite, isProt, massOk, eraseGo, armWrite, progGo, tagHit;

   always_comb begin
      actCtl = dp_ff.addr[ARRAY_SEL_BIT] ? ctrl2_ff : ctrl1_ff;
      pageTag = dp_ff.addr[ARRAY_SEL_BIT:PAGE_LSB];
      arrayWrite = regWrite && (dp_ff.region == RG_ARRAY);
      isProt = pageProtected(pageTag[3:0], protect_ff);
      massOk = (protect_ff >= 8'(PAGES_PER_ARRAY));
      tagHit = armed_ff && (armedTag_ff == pageTag);
      eraseGo = arrayWrite && actCtl[CTL_ERASE] && (actCtl[CTL_MASS] ? massOk : !isProt);
      // first write only arms the page
      armWrite = arrayWrite && !actCtl[CTL_ERASE] && actCtl[CTL_PROGRAM] && !tagHit;
      progGo = arrayWrite && !actCtl[CTL_ERASE] && actCtl[CTL_PROGRAM] && tagHit && !isProt;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         armed_ff <= 1'b0;
         armedTag_ff <= '0;
      end else if (armWrite) begin
         armed_ff <= 1'b1;
         armedTag_ff <= pageTag;
      end else if (eraseGo || !(ctrl1_ff[CTL_PROGRAM] || ctrl2_ff[CTL_PROGRAM])) begin
         armed_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Sequencer
   logic [MEM_AW-1:0] fillAddr_ff, fillEnd_ff, memWaddr, pageBase;
   logic isProgOp_ff, timerDone, memWe;
   logic [US_W-1:0] usLoad;
   logic [BUS_W-1:0] memWdata;

   // program pulse inside the byte limit
   assign usLoad = progGo ? PROG_US_CNT :
      (actCtl[CTL_MASS] ? MASS_ERASE_US_CNT : PAGE_ERASE_US_CNT);
   // page base drops the word-in-page bits
   assign pageBase = {pageTag, 5'h00};

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         opState_ff <= OP_IDLE;
      end else begin
         case (opState_ff)
            OP_IDLE: begin
               if (eraseGo || progGo) begin
                  opState_ff <= OP_TIMING;
               end
            end
            OP_TIMING: begin
               if (timerDone) begin
                  opState_ff <= isProgOp_ff ? OP_IDLE : OP_FILL;
               end
            end
            OP_FILL: begin
               if (fillAddr_ff == fillEnd_ff) begin
                  opState_ff <= OP_IDLE;
               end
            end
            default: opState_ff <= OP_IDLE;
         endcase
      end
   end

   // page span, or whole array for mass
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fillAddr_ff <= '0;
         fillEnd_ff <= '0;
         isProgOp_ff <= 1'b0;
      end else if (eraseGo) begin
         isProgOp_ff <= 1'b0;
         if (actCtl[CTL_MASS]) begin
            fillAddr_ff <= {pageTag[TAG_W-1], 9'h000};
            fillEnd_ff <= {pageTag[TAG_W-1], 9'h1FF};
         end else begin
            fillAddr_ff <= pageBase;
            fillEnd_ff <= pageBase + 10'(PAGE_WORDS - 1);
         end
      end else if (progGo) begin
         isProgOp_ff <= 1'b1;
      end else if (opState_ff == OP_FILL) begin
         fillAddr_ff <= fillAddr_ff + 10'(1);
      end
   end

   always_comb begin
      memWe = progGo || (opState_ff == OP_FILL);
      memWaddr = progGo ? dp_ff.addr[ARRAY_SEL_BIT:WORD_LSB] : fillAddr_ff;
      memWdata = progGo ? hwdata : ERASED_WORD;
   end

   flash_op_timer u_timer (
      .clk(sys_clk),
      .rstn(rstn),
      .start(eraseGo || progGo),
      .usLoad(usLoad),
      .done(timerDone)
   );

   flash_word_mem u_mem (
      .clk(sys_clk),
      .we(memWe),
      .waddr(memWaddr),
      .wdata(memWdata),
      .raddr(dp_ff.addr[ARRAY_SEL_BIT:WORD_LSB]),
      .rdata(memRdata)
   );

   // ==========================================================
   // Checks
   logic [12:0] progBusyCnt_ff;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         progBusyCnt_ff <= '0;
      end else if (progGo) begin
         progBusyCnt_ff <= '0;
      end else if (busy && isProgOp_ff) begin
         progBusyCnt_ff <= progBusyCnt_ff + 13'(1);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_prog_max;
      busy && isProgOp_ff |-> progBusyCnt_ff < 13'(PROG_MAX_CYC);
   endproperty
   a_prog_max: assert property (p_prog_max) else $error("program too long");
   property p_read_blocked;
      dpArrayRead && busy |-> !hreadyout;
   endproperty
   a_read_blocked: assert property (p_read_blocked) else $error("read during busy");
   property p_fill_ones;
      opState_ff == OP_FILL |-> memWe && memWdata == ERASED_WORD;
   endproperty
   a_fill_ones: assert property (p_fill_ones) else $error("erase not ones");
   property p_page_span;
      eraseGo && !actCtl[CTL_MASS] |=> fillEnd_ff - fillAddr_ff == 10'(PAGE_WORDS - 1);
   endproperty
   a_page_span: assert property (p_page_span) else $error("bad page span");
   property p_mass_span;
      eraseGo && actCtl[CTL_MASS] |=> fillAddr_ff[8:0] == 9'h000 && fillEnd_ff[8:0] == 9'h1FF;
   endproperty
   a_mass_span: assert property (p_mass_span) else $error("bad mass span");
   property p_arm_no_write;
      armWrite |-> !memWe ##1 armed_ff && armedTag_ff == $past(pageTag);
   endproperty
   a_arm_no_write: assert property (p_arm_no_write) else $error("dummy write wrong");
   property p_prot_write;
      regWrite && dp_ff.region == RG_PROTECT |=> protect_ff == $past(hwdata[7:0]);
   endproperty
   a_prot_write: assert property (p_prot_write) else $error("protect not stored");
   property p_prot_block;
      arrayWrite && isProt && !actCtl[CTL_MASS] |-> !progGo && !eraseGo;
   endproperty
   a_prot_block: assert property (p_prot_block) else $error("protected page hit");
   property p_ctl_upper;
      regWrite && dp_ff.region == RG_CTRL1 |=> ctrl1_ff[7:3] == 5'h00;
   endproperty
   a_ctl_upper: assert property (p_ctl_upper) else $error("upper bits kept");
   property p_prog_done;
      progGo |=> busy [*8];
   endproperty
   a_prog_done: assert property (p_prog_done) else $error("no busy after program");
   c_page_erase: cover property (eraseGo && !actCtl[CTL_MASS]);
   c_mass_erase: cover property (eraseGo && actCtl[CTL_MASS]);
   c_program: cover property (progGo);
   c_stalled_read: cover property (dpArrayRead && busy);

endmodule // flash_row_page_control

// file: hdl/flash_pkg.sv
package flash_pkg;

   // ==========================================================
   // Bus
   localparam int BUS_W = 32;
   localparam int ADDR_W = 16;
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [15:0] HIGH_ADDR_ZERO = 16'h0000;

   // ==========================================================
   // Register map
   localparam logic [15:0] ADDR_CTRL1 = 16'hFF88;
   localparam logic [15:0] ADDR_CTRL2 = 16'hFE08;
   localparam logic [15:0] ADDR_PROTECT = 16'hFF8C;
   localparam logic [15:0] ADDR_STATUS = 16'hFF90;
   localparam logic [15:0] ARRAY_TOP = 16'h1000;

   localparam int CTL_PROGRAM = 0;
   localparam int CTL_ERASE = 1;
   localparam int CTL_MASS = 2;
   localparam logic [7:0] CTL_MASK = 8'h07;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] PROTECT_RESET = 8'hFF;
   localparam int STAT_BUSY = 0;
   localparam int STAT_ARMED = 1;

   // ==========================================================
   // Array geometry
   localparam int WORD_BYTES = 4;
   localparam int PAGE_BYTES = 128;
   localparam int ROW_BYTES = 64;
   localparam int ROWS_PER_PAGE = PAGE_BYTES / ROW_BYTES;
   localparam int ARRAY_BYTES = 2048;
   localparam int PAGE_WORDS = PAGE_BYTES / WORD_BYTES;
   localparam int PAGES_PER_ARRAY = ARRAY_BYTES / PAGE_BYTES;
   localparam int MEM_WORDS = 2 * ARRAY_BYTES / WORD_BYTES;
   localparam int MEM_AW = 10;
   localparam int WORD_LSB = 2;
   localparam int PAGE_LSB = 7;
   localparam int ARRAY_SEL_BIT = 11;
   localparam int TAG_W = 5;
   localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
   localparam int PROG_TIME_US = 30;
   localparam int PROG_MAX_US = 40;
   localparam int PAGE_ERASE_MS = 1;
   localparam int MASS_ERASE_MS = 4;
   localparam int US_W = 12;
   localparam int PRESCALE_W = 7;
   localparam logic [6:0] PRESCALE_LAST = 7'(CYC_PER_US - 1);
   localparam logic [11:0] PROG_US_CNT = 12'(PROG_TIME_US);
   localparam logic [11:0] PAGE_ERASE_US_CNT = 12'(PAGE_ERASE_MS * 1000);
   localparam logic [11:0] MASS_ERASE_US_CNT = 12'(MASS_ERASE_MS * 1000);
   localparam int PROG_MAX_CYC = PROG_MAX_US * CYC_PER_US;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      RG_NONE, RG_CTRL1, RG_CTRL2, RG_PROTECT, RG_STATUS, RG_ARRAY
   } region_t;

   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_TIMING = 2'b01,
      OP_FILL = 2'b11
   } op_state_t;

   typedef struct packed {
      logic active;
      logic write;
      region_t region;
      logic [15:0] addr;
   } dphase_t;

endpackage

// file: hdl/flash_word_mem.sv
`timescale 1ns/1ps
module flash_word_mem (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [flash_pkg::MEM_AW-1:0] waddr,
   input wire logic [flash_pkg::BUS_W-1:0] wdata,
   // Read port
   input wire logic [flash_pkg::MEM_AW-1:0] raddr,
   output logic [flash_pkg::BUS_W-1:0] rdata
);
   import flash_pkg::*;

   logic [BUS_W-1:0] cells [MEM_WORDS];

   always_ff @(posedge clk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= cells[raddr];
   end

endmodule // flash_word_mem

// file: hdl/flash_op_timer.sv
`timescale 1ns/1ps
module flash_op_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic start,
   input wire logic [flash_pkg::US_W-1:0] usLoad,
   output logic done
);
   import flash_pkg::*;

   logic [PRESCALE_W-1:0] prescale_ff;
   logic [US_W-1:0] usLeft_ff;
   logic running_ff;
   logic usTick;

   // ==========================================================
   // Microsecond tick, restarted so every interval is whole
   assign usTick = (prescale_ff == PRESCALE_LAST);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prescale_ff <= '0;
      end else if (start || usTick) begin
         prescale_ff <= '0;
      end else begin
         prescale_ff <= prescale_ff + 7'(1);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         usLeft_ff <= '0;
         running_ff <= 1'b0;
      end else if (start) begin
         usLeft_ff <= usLoad;
         running_ff <= 1'b1;
      end else if (running_ff && usTick) begin
         usLeft_ff <= usLeft_ff - 12'(1);
         running_ff <= (usLeft_ff != 12'(1));
      end
   end

   assign done = running_ff && usTick && (usLeft_ff == 12'(1));

endmodule // flash_op_timer

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import flash_pkg::*;

   // ==========================================================
   // Signals
   localparam int LIM = 5000;
   localparam int ERASE_CYC = PAGE_ERASE_MS * 1000 * CYC_PER_US;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic flashBusy;
   logic [31:0] hrdata;
   logic dpRead = 1'b0;
   logic [31:0] expQ[$];
   logic [31:0] rng = 32'h0000ACFD;
   logic [31:0] d0, d1, d2;
   int numErrors = 0;
   int checks = 0;
   int n;

   always #5 sys_clk = ~sys_clk;
   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   flash_row_page_control dut_u (
      .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flashBusy(flashBusy)
   );

   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic final_report;
      $display("errors %0d checks %0d", numErrors, checks);
      if (numErrors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Entered and left just after a rising edge, so transfers chain back to back
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < LIM);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < LIM);
      if (k >= LIM) begin
         numErrors++;
         $display("[ERR] bus wait expected ready seen stall");
         final_report();
      end
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      expQ.push_back(e);
      xfer(a, 1'b0, 32'h0);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic waitBusy(input int lim, output int c);
      c = 0;
      do begin @(posedge sys_clk); c++; end while (flashBusy === 1'b1 && c < lim);
      if (flashBusy === 1'b1) begin
         numErrors++;
         $display("[ERR] busy wait expected idle seen busy");
         final_report();
      end
   endtask

   // ==========================================================
   // Monitor: read data is taken at the edge that ends its data phase
   always @(posedge sys_clk) begin
      if (dpRead && hreadyout === 1'b1) begin
         if (expQ.size() == 0)
            chk("read queue", 32'h1, 32'h0);
         else
            chk("hrdata", expQ.pop_front(), hrdata);
         chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
      end
      if (hreadyout === 1'b1)
         dpRead <= hsel && htrans[HTRANS_ACTIVE_BIT] && !hwrite;
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd({16'h0, ADDR_CTRL1}, {24'h0, CTRL_RESET});
      rd({16'h0, ADDR_CTRL2}, {24'h0, CTRL_RESET});
      rd({16'h0, ADDR_PROTECT}, {24'h0, PROTECT_RESET});
      rd({16'h0, ADDR_STATUS}, 32'h0);
      wr(32'h0000FF84, rng);
      rd(32'h0000FF84, 32'h0);
      wr({16'h0, ADDR_CTRL2}, 32'hFFFFFFFC);
      rd({16'h0, ADDR_CTRL2}, 32'h00000004);
      wr({16'h0, ADDR_CTRL2}, 32'h0);
      // Page erase of the first page, then the whole page reads ones
      wr({16'h0, ADDR_CTRL1}, 32'h2);
      wr(32'h00000040, xs(rng));
      waitBusy(ERASE_CYC + 10000, n);
      chk("erase busy length", 32'h1, {31'h0, n > ERASE_CYC});
      for (int i = 0; i < PAGE_WORDS; i++)
         rd(32'(i * WORD_BYTES), ERASED_WORD);
      // Program: dummy write arms the page, then data words
      wr({16'h0, ADDR_CTRL1}, 32'h1);
      rng = xs(rng);
      wr(32'h00000010, rng);
      // Status: armed set, not busy
      rd({16'h0, ADDR_STATUS}, 32'h00000002);
      rng = xs(rng);
      d0 = rng;
      wr(32'h00000004, d0);
      // Status: armed and busy while the pulse runs
      rd({16'h0, ADDR_STATUS}, 32'h00000003);
      waitBusy(LIM, n);
      chk("program busy length", 32'h1, {31'h0, n > 1 && n <= PROG_MAX_CYC + 1});
      rng = xs(rng);
      d1 = rng;
      rng = xs(rng);
      d2 = rng;
      // Second write stalls until the first pulse is over
      wr(32'h00000040, d1);
      wr(32'h00000044, d2);
      rd(32'h00000004, d0);
      rd(32'h00000040, d1);
      rd(32'h00000044, d2);
      rd(32'h00000008, ERASED_WORD);
      rd(32'h00000010, ERASED_WORD);
      // Protection from page zero up: program and erase are dropped
      wr({16'h0, ADDR_PROTECT}, 32'h0);
      rd({16'h0, ADDR_PROTECT}, 32'h0);
      wr(32'h0000000C, d0);
      waitBusy(LIM, n);
      chk("protected program busy", 32'h1, {31'h0, n == 1});
      rd(32'h0000000C, ERASED_WORD);
      wr({16'h0, ADDR_CTRL1}, 32'h2);
      wr(32'h00000000, d1);
      waitBusy(LIM, n);
      chk("protected erase busy", 32'h1, {31'h0, n == 1});
      rd(32'h00000004, d0);
      // Mass erase is refused while any page is protected
      wr({16'h0, ADDR_CTRL1}, 32'h6);
      wr(32'h00000000, d1);
      waitBusy(LIM, n);
      chk("protected mass erase busy", 32'h1, {31'h0, n == 1});
      rd(32'h00000004, d0);
      wr({16'h0, ADDR_CTRL1}, 32'h0);
      wr({16'h0, ADDR_PROTECT}, {24'h0, PROTECT_RESET});
      rd({16'h0, ADDR_PROTECT}, {24'h0, PROTECT_RESET});
      repeat (2) @(posedge sys_clk);
      chk("read queue empty", 32'h0, 32'(expQ.size()));
      final_report();
   end
endmodule // tb_top
